// >>> include/pbh_regs.vh
// Contract
// - Supports 66MHz full, 50MHz reduced, slower too
// - Configuration done sets target-not-ready arbitration bit 2
// - Status bit 5 writable by CPU or agent
// - Slave mode: EEPROM loads configuration via select
// - EEPROM select pin follows PIO register bit 0
// - Errored PCI cycle returns all-ones data
// - Errored cycle raises bus error to core
// - Empty-slot config read returns all-ones, error
// - Mask bit suppresses bus errors; resets clear
// - Clearing config-address enable resets slave machine
// - Device and vendor identifiers are read-only
`ifndef PBH_REGS_VH
`define PBH_REGS_VH

// Register byte addresses
`define PBH_ROM_SEL_ADDR 32'h18000610
`define PBH_ARB_ADDR 32'h18000500
`define PBH_STAT_ADDR 32'h18000504
`define PBH_BERR_ADDR 32'h18000508
`define PBH_CFGA_ADDR 32'h1800050c
`define PBH_CFGD_ADDR 32'h18000510
`define PBH_ID_ADDR 32'h18000514
`define PBH_CAP_ADDR 32'h18000518
// PCI memory window: addresses with top bits 3'b001
`define PBH_WIN_TAG 3'h1

// Field positions
`define PBH_ROM_SEL_BIT 0
`define PBH_ARB_TNR_BIT 2
`define PBH_STAT_FAST_BIT 5
`define PBH_BERR_MASK_BIT 0
`define PBH_BERR_FLAG_BIT 1
`define PBH_CFGA_EN_BIT 31

// Reset values
`define PBH_CFGA_RST 32'h00000000
`define PBH_ALL_ONES 32'hffffffff

// Clock rate capability in MHz
`define PBH_MHZ_FULL 8'h42
`define PBH_MHZ_REDUCED 8'h32
`define PBH_MHZ_LEGACY 8'h21

// Decode indices
`define PBH_DEC_NONE 4'h0
`define PBH_DEC_ROM 4'h1
`define PBH_DEC_ARB 4'h2
`define PBH_DEC_STAT 4'h3
`define PBH_DEC_BERR 4'h4
`define PBH_DEC_CFGA 4'h5
`define PBH_DEC_CFGD 4'h6
`define PBH_DEC_ID 4'h7
`define PBH_DEC_CAP 4'h8
`define PBH_DEC_WIN 4'h9

// External agent register indices
`define PBH_TGT_ID 2'h0
`define PBH_TGT_STAT 2'h1

`endif

// >>> rtl/pbh_tgt_sm.v
`timescale 1ns/100ps
`default_nettype none
`include "pbh_regs.vh"

module pbh_tgt_sm (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire soft_rst,
  // External configuring agent
  input wire tgt_req,
  input wire tgt_we,
  input wire [1:0] tgt_reg,
  input wire [31:0] tgt_wdata,
  output reg tgt_ack,
  output reg [31:0] tgt_rdata,
  // Register side
  input wire [31:0] id_word,
  input wire [31:0] stat_word,
  output reg fast_wr,
  output reg fast_val
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DECODE = 2'h1;
  localparam [1:0] ST_ACK = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg we_q;
  reg [1:0] reg_q;
  reg [31:0] wdata_q;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (tgt_req) next_state = ST_DECODE;
      ST_DECODE: next_state = ST_ACK;
      ST_ACK: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Soft reset drops any half-done access so no dummy cycle is needed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      we_q <= 1'b0;
      reg_q <= 2'h0;
      wdata_q <= 32'h00000000;
      tgt_ack <= 1'b0;
      tgt_rdata <= 32'h00000000;
      fast_wr <= 1'b0;
      fast_val <= 1'b0;
    end else if (soft_rst) begin
      state <= ST_IDLE;
      tgt_ack <= 1'b0;
      fast_wr <= 1'b0;
    end else begin
      state <= next_state;
      tgt_ack <= (state == ST_DECODE);
      fast_wr <= (state == ST_DECODE) && we_q && (reg_q == `PBH_TGT_STAT);
      fast_val <= wdata_q[`PBH_STAT_FAST_BIT];
      if (state == ST_IDLE && tgt_req) begin
        we_q <= tgt_we;
        reg_q <= tgt_reg;
        wdata_q <= tgt_wdata;
      end
      if (state == ST_DECODE) begin
        // Identifier word ignores writes
        tgt_rdata <= (reg_q == `PBH_TGT_ID) ? id_word :
                     (reg_q == `PBH_TGT_STAT) ? stat_word : 32'h00000000;
      end
    end
  end
endmodule // pbh_tgt_sm

`default_nettype wire

// >>> rtl/pbh_host_cyc.v
`timescale 1ns/100ps
`default_nettype none
`include "pbh_regs.vh"

module pbh_host_cyc (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Request from bus side
  input wire start,
  input wire start_cfg,
  input wire start_we,
  input wire [31:0] start_addr,
  input wire [31:0] start_wdata,
  output reg done,
  output reg err,
  output reg [31:0] rdata,
  // PCI cycle engine
  output reg pci_req,
  output reg pci_cfg,
  output reg pci_we,
  output reg [31:0] pci_addr,
  output reg [31:0] pci_wdata,
  input wire pci_done,
  input wire pci_err,
  input wire [31:0] pci_rdata
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;

  reg [1:0] state;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      done <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h00000000;
      pci_req <= 1'b0;
      pci_cfg <= 1'b0;
      pci_we <= 1'b0;
      pci_addr <= 32'h00000000;
      pci_wdata <= 32'h00000000;
    end else begin
      done <= 1'b0;
      err <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_WAIT;
            pci_req <= 1'b1;
            pci_cfg <= start_cfg;
            pci_we <= start_we;
            pci_addr <= start_addr;
            pci_wdata <= start_wdata;
          end
        end
        ST_WAIT: begin
          if (pci_done) begin
            state <= ST_IDLE;
            pci_req <= 1'b0;
            done <= 1'b1;
            err <= pci_err;
            // Empty slots master-abort and land here too
            rdata <= pci_err ? `PBH_ALL_ONES : pci_rdata;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // pbh_host_cyc

`default_nettype wire

// >>> rtl/pbh_bridge.v
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pbh_regs.vh"

module pbh_bridge #(
  parameter FULL_VARIANT = 1,
  // Arbitrary neutral identification values
  parameter [15:0] DEVICE_ID = 16'h5a01,
  parameter [15:0] VENDOR_ID = 16'h7e21
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // PCI cycle engine
  output wire pci_req,
  output wire pci_cfg,
  output wire pci_we,
  output wire [31:0] pci_addr,
  output wire [31:0] pci_wdata,
  input wire pci_done,
  input wire pci_err,
  input wire [31:0] pci_rdata,
  // Configuration progress
  input wire cfg_done,
  // External configuring agent
  input wire tgt_req,
  input wire tgt_we,
  input wire [1:0] tgt_reg,
  input wire [31:0] tgt_wdata,
  output wire tgt_ack,
  output wire [31:0] tgt_rdata,
  // Core and board side
  output reg cpu_bus_err,
  output reg config_rom_sel,
  output reg tgt_not_ready,
  output reg fast_capable
);

  function [3:0] dec;
    input [31:0] a;
    begin
      if (a[31:29] == `PBH_WIN_TAG) dec = `PBH_DEC_WIN;
      else case (a)
        `PBH_ROM_SEL_ADDR: dec = `PBH_DEC_ROM;
        `PBH_ARB_ADDR: dec = `PBH_DEC_ARB;
        `PBH_STAT_ADDR: dec = `PBH_DEC_STAT;
        `PBH_BERR_ADDR: dec = `PBH_DEC_BERR;
        `PBH_CFGA_ADDR: dec = `PBH_DEC_CFGA;
        `PBH_CFGD_ADDR: dec = `PBH_DEC_CFGD;
        `PBH_ID_ADDR: dec = `PBH_DEC_ID;
        `PBH_CAP_ADDR: dec = `PBH_DEC_CAP;
        default: dec = `PBH_DEC_NONE;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i]) merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // Register state
  reg [31:0] cfga;
  reg berr_mask;
  reg berr_flag;
  reg launched;

  wire [3:0] sel = dec(paddr);
  wire is_pci = (sel == `PBH_DEC_WIN) || (sel == `PBH_DEC_CFGD);
  wire access = psel && penable && !pready;
  wire wr_fire = psel && penable && pready && pwrite;

  // Config data port needs the enable bit, else it is refused locally
  wire cfg_ok = cfga[`PBH_CFGA_EN_BIT];
  wire pci_ok = (sel == `PBH_DEC_WIN) || cfg_ok;
  wire cyc_start = access && is_pci && pci_ok && !launched;

  wire cyc_done;
  wire cyc_err;
  wire [31:0] cyc_rdata;
  wire fast_wr;
  wire fast_val;
  wire [31:0] next_cfga = merge(cfga, pwdata, pstrb);

  // Only a falling enable written by software resets the slave side
  wire slave_rst = wr_fire && (sel == `PBH_DEC_CFGA) &&
                   cfga[`PBH_CFGA_EN_BIT] && !next_cfga[`PBH_CFGA_EN_BIT];

  wire [31:0] id_word = {DEVICE_ID, VENDOR_ID};
  wire [31:0] stat_word = {26'h0000000, fast_capable, 5'h00};
  wire [7:0] max_mhz = (FULL_VARIANT != 0) ? `PBH_MHZ_FULL : `PBH_MHZ_REDUCED;

  pbh_host_cyc u_host_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .start_cfg(sel == `PBH_DEC_CFGD),
    .start_we(pwrite),
    .start_addr((sel == `PBH_DEC_CFGD) ? cfga : paddr),
    .start_wdata(pwdata),
    .done(cyc_done),
    .err(cyc_err),
    .rdata(cyc_rdata),
    .pci_req(pci_req),
    .pci_cfg(pci_cfg),
    .pci_we(pci_we),
    .pci_addr(pci_addr),
    .pci_wdata(pci_wdata),
    .pci_done(pci_done),
    .pci_err(pci_err),
    .pci_rdata(pci_rdata)
  );

  pbh_tgt_sm u_tgt_sm (
    .pclk(pclk),
    .presetn(presetn),
    .soft_rst(slave_rst),
    .tgt_req(tgt_req),
    .tgt_we(tgt_we),
    .tgt_reg(tgt_reg),
    .tgt_wdata(tgt_wdata),
    .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata),
    .id_word(id_word),
    .stat_word(stat_word),
    .fast_wr(fast_wr),
    .fast_val(fast_val)
  );

  // Read mux for local registers
  reg [31:0] rd_local;
  always @* begin
    rd_local = 32'h00000000;
    case (sel)
      `PBH_DEC_ROM: rd_local[`PBH_ROM_SEL_BIT] = config_rom_sel;
      `PBH_DEC_ARB: rd_local[`PBH_ARB_TNR_BIT] = tgt_not_ready;
      `PBH_DEC_STAT: rd_local = stat_word;
      `PBH_DEC_BERR: begin
        rd_local[`PBH_BERR_MASK_BIT] = berr_mask;
        rd_local[`PBH_BERR_FLAG_BIT] = berr_flag;
      end
      `PBH_DEC_CFGA: rd_local = cfga;
      `PBH_DEC_ID: rd_local = id_word;
      `PBH_DEC_CAP: rd_local = {8'h00, `PBH_MHZ_LEGACY, 8'h00, max_mhz};
      default: rd_local = 32'h00000000;
    endcase
  end

  // APB answer: local registers answer on the second access cycle,
  // PCI cycles two cycles after the engine raises pci_done
  wire local_hit = (sel != `PBH_DEC_NONE) && !is_pci;
  wire refused = (sel == `PBH_DEC_NONE) || (is_pci && !pci_ok);
  wire next_pready = access && (local_hit || refused || (launched && cyc_done));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      launched <= 1'b0;
    end else begin
      pready <= next_pready;
      if (cyc_start) launched <= 1'b1;
      else if (next_pready) launched <= 1'b0;
      if (next_pready) begin
        if (is_pci && pci_ok) begin
          prdata <= cyc_rdata;
          pslverr <= cyc_err;
        end else if (refused) begin
          prdata <= (sel == `PBH_DEC_CFGD) ? `PBH_ALL_ONES : 32'h00000000;
          pslverr <= 1'b1;
        end else begin
          prdata <= pwrite ? 32'h00000000 : rd_local;
          pslverr <= 1'b0;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Software-visible control and status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_rom_sel <= 1'b0;
      tgt_not_ready <= 1'b0;
      fast_capable <= 1'b0;
      berr_mask <= 1'b0;
      berr_flag <= 1'b0;
      cfga <= `PBH_CFGA_RST;
      cpu_bus_err <= 1'b0;
    end else begin
      if (wr_fire && sel == `PBH_DEC_ROM && pstrb[0])
        config_rom_sel <= pwdata[`PBH_ROM_SEL_BIT];
      // Configuration completion wins over a clearing write
      if (cfg_done)
        tgt_not_ready <= 1'b1;
      else if (wr_fire && sel == `PBH_DEC_ARB && pstrb[0])
        tgt_not_ready <= pwdata[`PBH_ARB_TNR_BIT];
      // Agent write lands after a same-cycle CPU write
      if (fast_wr)
        fast_capable <= fast_val;
      else if (wr_fire && sel == `PBH_DEC_STAT && pstrb[0])
        fast_capable <= pwdata[`PBH_STAT_FAST_BIT];
      if (wr_fire && sel == `PBH_DEC_BERR && pstrb[0])
        berr_mask <= pwdata[`PBH_BERR_MASK_BIT];
      // Sticky error flag, write one to clear, new error wins
      if (cyc_done && cyc_err)
        berr_flag <= 1'b1;
      else if (wr_fire && sel == `PBH_DEC_BERR && pstrb[0] && pwdata[`PBH_BERR_FLAG_BIT])
        berr_flag <= 1'b0;
      if (wr_fire && sel == `PBH_DEC_CFGA)
        cfga <= next_cfga;
      // Masking hides the exception only; the flag still records it
      cpu_bus_err <= cyc_done && cyc_err && !berr_mask;
    end
  end
endmodule // pbh_bridge

`default_nettype wire

// >>> verif/pbh_chk_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbh_regs.vh"
module pbh_chk #(
  parameter [15:0] DEVICE_ID = 16'h5a01,
  parameter [15:0] VENDOR_ID = 16'h7e21
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // PCI engine
  input wire logic pci_req,
  input wire logic pci_cfg,
  input wire logic pci_done,
  input wire logic pci_err,
  // Agent and status
  input wire logic cfg_done,
  input wire logic tgt_req,
  input wire logic tgt_we,
  input wire logic [1:0] tgt_reg,
  input wire logic [31:0] tgt_wdata,
  input wire logic tgt_ack,
  input wire logic cpu_bus_err,
  input wire logic config_rom_sel,
  input wire logic tgt_not_ready,
  input wire logic fast_capable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire apb_end = psel && penable && pready;
  wire pci_fail = pci_req && pci_done && pci_err;
  // Shadow of the mask bit, so the core-error relation can be checked from ports
  logic mask_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mask_q <= 1'b0;
    else if (apb_end && pwrite && paddr == `PBH_BERR_ADDR && pstrb[0])
      mask_q <= pwdata[0];
  end
  chk_rom_sel_follow: assert property (apb_end && pwrite && paddr == `PBH_ROM_SEL_ADDR
    && pstrb[0] |=> config_rom_sel == $past(pwdata[0])) else $error("rom select mismatch");
  chk_err_all_ones: assert property (pci_fail |-> ##2 (pready && pslverr
    && prdata == `PBH_ALL_ONES)) else $error("errored cycle data wrong");
  chk_cfg_abort_end: assert property (pci_fail && pci_cfg |=> !pci_req ##1
    (pready && pslverr)) else $error("config abort end wrong");
  chk_err_to_core: assert property (pci_fail && !mask_q |-> ##2 cpu_bus_err)
    else $error("bus error not raised");
  chk_mask_quiet: assert property (mask_q && pci_req && pci_done |-> ##2 !cpu_bus_err)
    else $error("masked bus error raised");
  chk_tnr_set: assert property (cfg_done |=> tgt_not_ready)
    else $error("not ready flag not set");
  chk_reset_flags: assert property ($rose(presetn) |-> !tgt_not_ready && !fast_capable
    && !config_rom_sel) else $error("flags not clear after reset");
  chk_agent_fast: assert property (tgt_ack && $past(tgt_req, 2) && $past(tgt_we, 2)
    && $past(tgt_reg, 2) == 2'h1 |=> fast_capable == $past(tgt_wdata[5], 3))
    else $error("agent fast write lost");
  chk_id_fixed: assert property (apb_end && !pwrite && paddr == `PBH_ID_ADDR |->
    prdata == {DEVICE_ID, VENDOR_ID}) else $error("id word wrong");
  cover property (pci_fail);
  cover property (tgt_ack);
  cover property (apb_end && paddr == `PBH_ROM_SEL_ADDR);
endmodule // pbh_chk
bind pbh_bridge pbh_chk #(.DEVICE_ID(DEVICE_ID), .VENDOR_ID(VENDOR_ID)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pci_req(pci_req), .pci_cfg(pci_cfg), .pci_done(pci_done),
  .pci_err(pci_err), .cfg_done(cfg_done), .tgt_req(tgt_req), .tgt_we(tgt_we),
  .tgt_reg(tgt_reg), .tgt_wdata(tgt_wdata), .tgt_ack(tgt_ack), .cpu_bus_err(cpu_bus_err),
  .config_rom_sel(config_rom_sel), .tgt_not_ready(tgt_not_ready),
  .fast_capable(fast_capable));
`default_nettype wire

// >>> verif/pbh_pci_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbh_pci_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] dly,
  // Cycle engine
  input wire logic pci_req,
  input wire logic pci_cfg,
  input wire logic [31:0] pci_addr,
  output logic pci_done,
  output logic pci_err,
  output logic [31:0] pci_rdata
);
  logic [7:0] cnt;
  // Only slot 0 is populated; memory with bit 28 set aborts
  wire fail = pci_cfg ? (pci_addr[15:11] != 5'h0) : pci_addr[28];
  wire [31:0] v = pci_addr ^ 32'h5a5a0000;
  // Data outside the done cycle is scrambled so a late sample cannot pass
  assign pci_rdata = pci_done ? v : ~v;
  // System error stays on the board and goes to the core's NMI; only cycle errors return
  assign pci_err = pci_done && fail;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h0;
      pci_done <= 1'b0;
    end else begin
      pci_done <= pci_req && cnt == dly;
      if (!pci_req)
        cnt <= 8'h0;
      else if (cnt <= dly)
        cnt <= cnt + 8'h1;
    end
  end
endmodule // pbh_pci_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbh_regs.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, cfg_done, tgt_req, tgt_we, arm, re;
  logic [31:0] paddr, pwdata, tgt_wdata, rv;
  logic [3:0] pstrb;
  logic [1:0] tgt_reg;
  logic [7:0] pdly;
  wire [31:0] prdata, pci_addr, pci_rdata, tgt_rdata;
  wire pready, pslverr, pci_req, pci_cfg, pci_done, pci_err, tgt_ack, pci_we;
  wire [31:0] pci_wdata;
  wire cpu_bus_err, config_rom_sel, tgt_not_ready, fast_capable;
  integer bad_count, n_checks, berr_n, ack_n, b0, n;
  localparam [31:0] IDW = {16'h5a01, 16'h7e21};
  localparam [31:0] ONES = 32'hffffffff;
  pbh_bridge dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pci_req(pci_req), .pci_cfg(pci_cfg),
    .pci_we(pci_we), .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_done(pci_done),
    .pci_err(pci_err),
    .pci_rdata(pci_rdata), .cfg_done(cfg_done), .tgt_req(tgt_req), .tgt_we(tgt_we),
    .tgt_reg(tgt_reg), .tgt_wdata(tgt_wdata), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata),
    .cpu_bus_err(cpu_bus_err), .config_rom_sel(config_rom_sel),
    .tgt_not_ready(tgt_not_ready), .fast_capable(fast_capable));
  pbh_pci_model u_pci (.pclk(pclk), .presetn(presetn), .dly(pdly), .pci_req(pci_req),
    .pci_cfg(pci_cfg), .pci_addr(pci_addr), .pci_done(pci_done), .pci_err(pci_err),
    .pci_rdata(pci_rdata));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (cpu_bus_err === 1'b1) berr_n = berr_n + 1;
    if (tgt_ack === 1'b1) ack_n = ack_n + 1;
  end
  task chk(input [63:0] seen, input [63:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Armed transfers start an agent read mid-access to collide with the write
  task xfer(input w, input [31:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (arm) tgt_req <= 1'b1;
    n = 0;
    @(posedge pclk);
    tgt_req <= 1'b0;
    while (pready !== 1'b1 && n < 300) begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n >= 300) bad_count = bad_count + 1;
    rv = prdata; re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task agent(input w, input [1:0] r, input [31:0] d);
    @(posedge pclk);
    tgt_req <= 1'b1; tgt_we <= w; tgt_reg <= r; tgt_wdata <= d;
    @(posedge pclk);
    tgt_req <= 1'b0;
    n = 0;
    while (tgt_ack !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    re = (n < 20);
  endtask
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  initial begin
    #(40 * 20000);
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    {psel, penable, pwrite, cfg_done, tgt_req, tgt_we, arm, re} = 8'h0;
    paddr = 32'h0; pwdata = 32'h0; tgt_wdata = 32'h0; tgt_reg = 2'h0; rv = 32'h0;
    pstrb = 4'hf; pdly = 8'h1; presetn = 1'b0;
    bad_count = 0; n_checks = 0; berr_n = 0; ack_n = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, `PBH_ROM_SEL_ADDR, 0); chk({re, rv}, {1'b0, 32'h0});
    xfer(0, `PBH_ARB_ADDR, 0); chk(rv[2], 1'b0);
    xfer(0, `PBH_STAT_ADDR, 0); chk(rv[5], 1'b0);
    xfer(0, `PBH_BERR_ADDR, 0); chk(rv[0], 1'b0);
    xfer(1, `PBH_ID_ADDR, 0); xfer(0, `PBH_ID_ADDR, 0); chk(rv, IDW);
    xfer(0, `PBH_CAP_ADDR, 0); chk({rv[23:16], rv[7:0]}, {8'h21, 8'h42});
    xfer(0, 32'h18000700, 0); chk({re, rv}, {1'b1, 32'h0});
    $display("test reset done");
    xfer(1, `PBH_ROM_SEL_ADDR, 1); settle; chk(config_rom_sel, 1'b1);
    xfer(1, `PBH_ROM_SEL_ADDR, 0); settle; chk(config_rom_sel, 1'b0);
    pstrb <= 4'he;
    xfer(1, `PBH_ROM_SEL_ADDR, 1); settle; chk(config_rom_sel, 1'b0);
    pstrb <= 4'hf;
    @(posedge pclk); cfg_done <= 1'b1;
    @(posedge pclk); cfg_done <= 1'b0;
    settle; chk(tgt_not_ready, 1'b1);
    xfer(0, `PBH_ARB_ADDR, 0); chk(rv[2], 1'b1);
    xfer(1, `PBH_ARB_ADDR, 0); settle; chk(tgt_not_ready, 1'b0);
    $display("test pins done");
    agent(1, 1, 32'h20); settle; chk(fast_capable, 1'b1);
    xfer(0, `PBH_STAT_ADDR, 0); chk(rv[5], 1'b1);
    agent(1, 0, 0); agent(0, 0, 0); chk(tgt_rdata, IDW);
    xfer(1, `PBH_STAT_ADDR, 0); settle; chk(fast_capable, 1'b0);
    $display("test agent done");
    xfer(1, `PBH_CFGA_ADDR, 32'h80000800); b0 = berr_n;
    xfer(0, `PBH_CFGD_ADDR, 0); chk({re, rv}, {1'b1, ONES});
    settle; chk(berr_n - b0, 1);
    xfer(0, `PBH_BERR_ADDR, 0); chk(rv[1], 1'b1);
    xfer(1, `PBH_BERR_ADDR, 32'h3); b0 = berr_n; pdly <= 8'h6;
    xfer(0, 32'h30000000, 0); chk({re, rv}, {1'b1, ONES});
    settle; chk(berr_n - b0, 0);
    xfer(1, `PBH_BERR_ADDR, 0);
    xfer(0, 32'h20000010, 0); chk({re, rv}, {1'b0, 32'h7a5a0010});
    xfer(1, 32'h20000020, 32'h1234abcd);
    chk({re, pci_we, pci_wdata}, {1'b0, 1'b1, 32'h1234abcd});
    xfer(1, `PBH_CFGA_ADDR, 32'h80000000);
    xfer(0, `PBH_CFGD_ADDR, 0); chk({re, rv}, {1'b0, 32'hda5a0000});
    $display("test pci done");
    arm = 1'b1; xfer(1, `PBH_CFGA_ADDR, 0); arm = 1'b0; b0 = ack_n;
    settle; settle; chk(ack_n - b0, 0);
    agent(0, 1, 0); chk(re, 1'b1);
    xfer(0, `PBH_CFGD_ADDR, 0); chk({re, rv}, {1'b1, ONES});
    $display("test slave reset done");
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
